// [core/pin_out_pkg.sv]
// Constants shared by the pin output-level register and its bus port.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package pin_out_pkg;
  // Bus geometry
  localparam int DATA_W = 32;
  localparam int ADR_W = 8;
  localparam int SEL_W = 4;
  // Register map
  localparam logic [7:0] LEVEL_REG_OFS = 8'h00;
  // Field layout of the output-level register
  localparam int PIN_COUNT = 12;
  localparam int CS_LSB = 0;
  localparam int CS_MAX = 8;
  localparam int ENA_BIT = 8;
  localparam int SCLK_BIT = 9;
  localparam int MOSI_BIT = 10;
  localparam int MISO_BIT = 11;
  // Reset value of the writable levels
  localparam logic [11:0] LEVEL_RESET = 12'h000;
  // Bus port phases, Gray coded
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_ACK = 1'b1
  } bus_phase_t;
endpackage

// [core/wb_reg_port.sv]
// Classic Wishbone slave front end: accepts one request and acks it one cycle later.
// Assumes the master holds cyc, stb and the request until it sees ack.
`timescale 1ns/1ns
module wb_reg_port #(
  parameter int ADR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone request
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [ADR_W-1:0] reg_ofs_i,
  // Decoded strobes toward the register file
  output logic accept_o,
  output logic write_o,
  output logic hit_o,
  // Wishbone answer
  output logic wb_ack_o
);

  typedef struct packed {
    pin_out_pkg::bus_phase_t phase;
  } port_state_t;

  port_state_t cur;
  port_state_t next_cur;

  // Word aligned decode; the low two address bits are ignored, lanes come from wb_sel_i
  always_comb begin
    next_cur = cur;
    accept_o = 1'b0;
    unique case (cur.phase)
      pin_out_pkg::PH_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          accept_o = 1'b1;
          next_cur.phase = pin_out_pkg::PH_ACK;
        end
      end
      pin_out_pkg::PH_ACK: begin
        // Ack drops after one cycle so a held request is never taken twice
        next_cur.phase = pin_out_pkg::PH_IDLE;
      end
    endcase
    write_o = accept_o && wb_we_i;
    hit_o = (wb_adr_i[ADR_W-1:2] == reg_ofs_i[ADR_W-1:2]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '{phase: pin_out_pkg::PH_IDLE};
    end else begin
      cur <= next_cur;
    end
  end

  assign wb_ack_o = (cur.phase == pin_out_pkg::PH_ACK);

endmodule // wb_reg_port

// [core/spi_pin_gpio_output_data.sv]
// Output-level register for the serial port pins used as general-purpose outputs.
// Assumes mode, direction and bit-set strobes come from logic on clk_i.
//
// Overview of operation
// - Bits 31 to 12 read as zero and ignore writes.
// - Bit 11 holds the MISO level, driven only in general-purpose output mode.
// - Bit 10 holds the MOSI level, driven only in general-purpose output mode.
// - Bit 9 holds the serial clock level, driven only in general-purpose output mode.
// - Bit 8 holds the enable pin level, driven only in general-purpose output mode.
// - Bits 7 to 0 hold chip-select levels, each driven only in general-purpose output mode.
// - All writable level bits reset to zero and are readable and writable.
// - Reading a level bit returns the stored level, not the level on its pin.
// - A one in the companion set register sets the level bit; a zero leaves it.
`timescale 1ns/1ns
module spi_pin_gpio_output_data #(
  parameter int CS_COUNT = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pin_out_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [pin_out_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [pin_out_pkg::DATA_W-1:0] wb_dat_i,
  output logic [pin_out_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Per-pin mode from the function and direction registers
  input wire logic [pin_out_pkg::PIN_COUNT-1:0] gpio_mode_i,
  input wire logic [pin_out_pkg::PIN_COUNT-1:0] gpio_dir_out_i,
  // Bit-set strobes from the companion set register, one cycle each
  input wire logic [pin_out_pkg::PIN_COUNT-1:0] level_set_i,
  // Serial core drive, used while a pin is in its serial function
  input wire logic [pin_out_pkg::PIN_COUNT-1:0] func_out_i,
  input wire logic [pin_out_pkg::PIN_COUNT-1:0] func_oe_i,
  // Level register contents toward the rest of the peripheral
  output logic [pin_out_pkg::PIN_COUNT-1:0] level_o,
  // MISO pin
  output logic miso_pin_o,
  output logic miso_pin_oe_o,
  // MOSI pin
  output logic mosi_pin_o,
  output logic mosi_pin_oe_o,
  // Serial clock pin
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  // Enable pin
  output logic slave_ready_pin_o,
  output logic slave_ready_pin_oe_o,
  // Chip-select pins
  output logic [CS_COUNT-1:0] chip_select_pin_o,
  output logic [CS_COUNT-1:0] chip_select_pin_oe_o
);

  localparam int PC = pin_out_pkg::PIN_COUNT;
  localparam int DW = pin_out_pkg::DATA_W;

  // Bits that exist on this build: the four control pins plus CS_COUNT selects
  function automatic logic [PC-1:0] implemented_mask(input int cs_count);
    logic [PC-1:0] m;
    m = '0;
    m[pin_out_pkg::ENA_BIT] = 1'b1;
    m[pin_out_pkg::SCLK_BIT] = 1'b1;
    m[pin_out_pkg::MOSI_BIT] = 1'b1;
    m[pin_out_pkg::MISO_BIT] = 1'b1;
    for (int i = 0; i < pin_out_pkg::CS_MAX; i++) begin
      if (i < cs_count) begin
        m[pin_out_pkg::CS_LSB + i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Byte enables widened to the level field; lane 1 covers bits 11 to 8
  function automatic logic [PC-1:0] lane_mask(input logic [pin_out_pkg::SEL_W-1:0] sel);
    logic [PC-1:0] m;
    m = '0;
    for (int i = 0; i < PC; i++) begin
      m[i] = sel[i / 8];
    end
    return m;
  endfunction

  localparam logic [PC-1:0] IMPL = implemented_mask(CS_COUNT);

  typedef struct packed {
    logic [PC-1:0] level;
    logic [PC-1:0] pin_out;
    logic [PC-1:0] pin_oe;
    logic [DW-1:0] rd_data;
  } regs_t;

  regs_t cur;
  regs_t next_cur;

  logic accept;
  logic write;
  logic hit;

  wb_reg_port #(
    .ADR_W(pin_out_pkg::ADR_W)
  ) bus_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .reg_ofs_i(pin_out_pkg::LEVEL_REG_OFS),
    .accept_o(accept),
    .write_o(write),
    .hit_o(hit),
    .wb_ack_o(wb_ack_o)
  );

  always_comb begin
    logic [PC-1:0] wmask;
    wmask = '0;
    next_cur = cur;
    // Unimplemented selects and bits 31 to 12 never store a write
    wmask = lane_mask(wb_sel_i) & IMPL;
    if (write && hit) begin
      next_cur.level = (cur.level & ~wmask) | (wb_dat_i[PC-1:0] & wmask);
    end
    // A set strobe in the cycle of a write wins over a written zero
    next_cur.level = next_cur.level | (level_set_i & IMPL);
    // Pins are computed from the next level so they move on the same edge
    for (int i = 0; i < PC; i++) begin
      if (gpio_mode_i[i] && gpio_dir_out_i[i]) begin
        next_cur.pin_out[i] = next_cur.level[i];
        next_cur.pin_oe[i] = IMPL[i];
      end else if (gpio_mode_i[i]) begin
        // General-purpose input: the level bit has no effect on the pin
        next_cur.pin_out[i] = 1'b0;
        next_cur.pin_oe[i] = 1'b0;
      end else begin
        next_cur.pin_out[i] = func_out_i[i] & IMPL[i];
        next_cur.pin_oe[i] = func_oe_i[i] & IMPL[i];
      end
    end
    // Read data is captured at acceptance and held while ack is up
    if (accept) begin
      next_cur.rd_data = '0;
      if (!wb_we_i && hit) begin
        next_cur.rd_data[PC-1:0] = cur.level;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur.level <= pin_out_pkg::LEVEL_RESET;
      cur.pin_out <= '0;
      cur.pin_oe <= '0;
      cur.rd_data <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Every pin output is a flip-flop bit; no gate stands after it
  assign wb_dat_o = cur.rd_data;
  assign level_o = cur.level;
  assign miso_pin_o = cur.pin_out[pin_out_pkg::MISO_BIT];
  assign miso_pin_oe_o = cur.pin_oe[pin_out_pkg::MISO_BIT];
  assign mosi_pin_o = cur.pin_out[pin_out_pkg::MOSI_BIT];
  assign mosi_pin_oe_o = cur.pin_oe[pin_out_pkg::MOSI_BIT];
  assign serial_clock_pin_o = cur.pin_out[pin_out_pkg::SCLK_BIT];
  assign serial_clock_pin_oe_o = cur.pin_oe[pin_out_pkg::SCLK_BIT];
  assign slave_ready_pin_o = cur.pin_out[pin_out_pkg::ENA_BIT];
  assign slave_ready_pin_oe_o = cur.pin_oe[pin_out_pkg::ENA_BIT];

  // Only the selects that exist reach a port; the rest stay reserved
  generate
    for (genvar g = 0; g < CS_COUNT; g++) begin : g_cs
      assign chip_select_pin_o[g] = cur.pin_out[pin_out_pkg::CS_LSB + g];
      assign chip_select_pin_oe_o[g] = cur.pin_oe[pin_out_pkg::CS_LSB + g];
    end
  endgenerate

endmodule // spi_pin_gpio_output_data

// [bench/pin_out_properties.sv]
// Checker for the pin output-level register and its pins.
// Assumes it is bound to spi_pin_gpio_output_data with eight chip selects.
`timescale 1ns/1ns
module pin_out_properties #(
  parameter int CS_COUNT = 8
) (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [11:0] gpio_mode_i, gpio_dir_out_i, level_set_i, func_out_i, func_oe_i,
  input wire logic [11:0] level_o,
  input wire logic miso_pin_o, miso_pin_oe_o, mosi_pin_o, mosi_pin_oe_o,
  input wire logic serial_clock_pin_o, serial_clock_pin_oe_o,
  input wire logic slave_ready_pin_o, slave_ready_pin_oe_o,
  input wire logic [CS_COUNT-1:0] chip_select_pin_o, chip_select_pin_oe_o
);
  // Pins gathered in register bit order
  wire logic [11:0] pins = {miso_pin_o, mosi_pin_o, serial_clock_pin_o, slave_ready_pin_o,
    chip_select_pin_o};
  wire logic [11:0] oes = {miso_pin_oe_o, mosi_pin_oe_o, serial_clock_pin_oe_o,
    slave_ready_pin_oe_o, chip_select_pin_oe_o};
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr = req && wb_we_i && wb_adr_i[7:2] == 6'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_latency_a: assert property (req |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  stray_ack_a: assert property (!$past(req) |-> !wb_ack_o) else $error("ack without request");
  reserved_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:12] == 20'h0)
    else $error("reserved bits not zero");
  read_data_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(level_set_i) == 12'h0 && $past(wb_adr_i[7:2]) == 6'h00
    |-> wb_dat_o[11:0] == level_o) else $error("read data differs");
  write_store_a: assert property (wr && wb_sel_i == 4'hf && level_set_i == 12'h0
    |=> level_o == $past(wb_dat_i[11:0])) else $error("write not stored");
  set_strobe_a: assert property (|level_set_i
    |=> (level_o & $past(level_set_i)) == $past(level_set_i)) else $error("set lost");
  level_hold_a: assert property (!wr && level_set_i == 12'h0 |=> $stable(level_o))
    else $error("level changed");
  pin_drive_a: assert property (!$past(rst_i) |-> oes ==
    $past(gpio_mode_i & gpio_dir_out_i | ~gpio_mode_i & func_oe_i))
    else $error("pin enable wrong");
  pin_level_a: assert property (!$past(rst_i) |-> pins ==
    ($past(gpio_mode_i & gpio_dir_out_i) & level_o | $past(~gpio_mode_i & func_out_i)))
    else $error("pin level wrong");
  write_c: cover property (wr);
  read_c: cover property (req && !wb_we_i);
  set_c: cover property (|level_set_i);
  gpio_out_c: cover property (&(gpio_mode_i & gpio_dir_out_i));
endmodule // pin_out_properties
bind spi_pin_gpio_output_data pin_out_properties #(.CS_COUNT(CS_COUNT)) i_props (.*);

// [bench/testbench.sv]
// Self-checking bench for the pin output-level register.
// Drives the Wishbone port and the pin controls itself; no far-side model.
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, cs, cs_oe;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic [11:0] mode = 12'h0, dir = 12'h0, set = 12'h0, fo = 12'h0, fe = 12'h0, lvl;
  logic mi, mi_oe, mo, mo_oe, sc, sc_oe, en, en_oe;
  logic [11:0] m [4] = '{12'hfff, 12'hfff, 12'hf0f, 12'h000};
  logic [11:0] d [4] = '{12'hfff, 12'h000, 12'hff0, 12'hfff};
  logic [11:0] lv [4] = '{12'h9a5, 12'h6c3, 12'habc, 12'h5f0};
  wire logic [11:0] pins = {mi, mo, sc, en, cs};
  wire logic [11:0] oes = {mi_oe, mo_oe, sc_oe, en_oe, cs_oe};
  int err_count = 0;
  int n_checks = 0;
  spi_pin_gpio_output_data i_spi_pin_gpio_output_data (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .gpio_mode_i(mode),
    .gpio_dir_out_i(dir), .level_set_i(set), .func_out_i(fo), .func_oe_i(fe),
    .level_o(lvl), .miso_pin_o(mi), .miso_pin_oe_o(mi_oe), .mosi_pin_o(mo),
    .mosi_pin_oe_o(mo_oe), .serial_clock_pin_o(sc), .serial_clock_pin_oe_o(sc_oe),
    .slave_ready_pin_o(en), .slave_ready_pin_oe_o(en_oe), .chip_select_pin_o(cs),
    .chip_select_pin_oe_o(cs_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; waits on ack, takes read data at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] v);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= v;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    // A missing ack counts as a mismatch; the run still ends in the tally
    if (ack !== 1'b1) err_count++;
    rd = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 4'hf, 32'h0);
    chk(rd, e);
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #2 clk_i = ~clk_i;
  initial begin
    #4000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h00, 32'h0);
    chk(oes, 12'h000);
    bus(1'b1, 8'h00, 4'hf, 32'hffff_fabc);
    rchk(8'h00, 32'h0000_0abc);
    bus(1'b1, 8'h00, 4'h1, 32'h0000_0f55);
    rchk(8'h00, 32'h0000_0a55);
    bus(1'b1, 8'h04, 4'hf, 32'h0000_0123);
    rchk(8'h04, 32'h0);
    rchk(8'h00, 32'h0000_0a55);
    bus(1'b1, 8'h00, 4'hf, 32'h0);
    @(posedge clk_i);
    set <= 12'h0a5;
    @(posedge clk_i);
    set <= 12'h000;
    rchk(8'h00, 32'h0000_00a5);
    // All eight chip selects exist, so every chip-select bit may be written
    for (int i = 0; i < 4; i++) begin
      mode <= m[i];
      dir <= d[i];
      fo <= 12'h3c3;
      fe <= 12'h5a5;
      bus(1'b1, 8'h00, 4'h3, {20'h0, lv[i]});
      chk(pins, m[i] & d[i] & lv[i] | ~m[i] & 12'h3c3);
      chk(oes, m[i] & d[i] | ~m[i] & 12'h5a5);
    end
    // Set strobe lands on the very edge that takes a write of zero
    fork
      bus(1'b1, 8'h00, 4'hf, 32'h0);
      begin
        @(posedge clk_i);
        set <= 12'h00f;
        @(posedge clk_i);
        set <= 12'h000;
      end
    join
    rchk(8'h00, 32'h0000_000f);
    // Reset again in mid-run; the level must clear
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(lvl, 32'h0);
    rchk(8'h00, 32'h0);
    tally_and_finish;
  end
endmodule // testbench
